/* File: hw/bcrc_map.svh */
// Purpose: Register offsets, field positions, reset values and timing for the byte CRC unit
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes: Definitions only
`ifndef BCRC_MAP_SVH
`define BCRC_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define BCRC_OFS_CONTROL 12'h000
`define BCRC_OFS_INPUT 12'h004
`define BCRC_OFS_SUM_LOW 12'h008
`define BCRC_OFS_SUM_HIGH 12'h00c
`define BCRC_ADDR_W 12

// ****************************************
// Fields and reset values
// ****************************************
`define BCRC_GEN_CHOICE_BIT 0
`define BCRC_CONTROL_RST 8'h00
`define BCRC_INPUT_RST 8'h00
`define BCRC_SUM_RST 16'h0000
`define BCRC_FB_CCITT 16'h1021
`define BCRC_FB_CRC16 16'h8005

// ****************************************
// Timing
// ****************************************
`define BCRC_UPDATE_CYCLES 1

`endif

/* File: hw/bcrc_pkg.sv */
// Purpose: Types shared by the byte CRC unit
// Assumes: Offsets and constants live in bcrc_map.svh
// Notes: Types only
package bcrc_pkg;

  // ****************************************
  // Generator selection
  // ****************************************
  typedef enum logic
  {
    BCRC_GEN_CCITT = 1'b0,
    BCRC_GEN_CRC16 = 1'b1
  } bcrc_gen_type;

  // ****************************************
  // Bus data phase bookkeeping
  // ****************************************
  typedef enum logic [1:0]
  {
    BCRC_ST_IDLE = 2'b00,
    BCRC_ST_WRITE = 2'b01,
    BCRC_ST_READ = 2'b11
  } bcrc_state_type;

  typedef struct packed
  {
    logic [11:0] addr;
    logic write;
  } bcrc_req_type;

endpackage

/* File: hw/bcrc_byte_step.sv */
// Purpose: One byte of the CRC update as pure combinational logic
// Assumes: Caller registers the result
// Notes: Eight shift steps are unrolled by a generate loop
`include "bcrc_map.svh"

module bcrc_byte_step
  import bcrc_pkg::*;
(
  input wire logic [15:0] sum_in,
  input wire logic [7:0] data_in,
  input wire bcrc_gen_type gen_sel,
  output logic [15:0] sum_out
);

  logic [15:0] stage [0:8];
  logic [15:0] feedback;

  assign feedback = (gen_sel == BCRC_GEN_CRC16) ? `BCRC_FB_CRC16 : `BCRC_FB_CCITT;
  assign stage[0] = {sum_in[15:8] ^ data_in, sum_in[7:0]};

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_bit
      // Top bit leaves on the shift and decides the feedback
      assign stage[i + 1] = {stage[i][14:0], 1'b0} ^ (stage[i][15] ? feedback : 16'h0000);
    end
  endgenerate

  assign sum_out = stage[8];

endmodule

/* File: hw/bcrc_top.sv */
// Purpose: Byte-wise CRC16 unit with an AHB-Lite register slave
// Assumes: Single word transfers, one slave, always OKAY
// Notes: Writes answer with zero wait states; reads add one wait state
//
// Overview of operation
// - Byte input register, sixteen-bit checksum register pair
// - Control bit picks 1021H or 8005H feedback
// - Only those two generators exist
// - Each input write folds byte into checksum
// - Update completes within one cycle
// - Byte XORed into checksum high byte first
// - Eight shifts left with zero fill
// - Feedback XORed when shifted-out bit set
// - Updates chain across successive bytes
// - Control reads only bit zero
// - High/low bytes readable, writable, reset zero
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`include "bcrc_map.svh"

module bcrc_top
  import bcrc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // ****************************************
  // Register state
  // ****************************************
  bcrc_gen_type gen_choice_ff, nxt_gen_choice;
  logic [7:0] byte_input_ff, nxt_byte_input;
  logic [15:0] running_checksum_ff, nxt_running_checksum;
  logic [15:0] stepped_sum;

  // ****************************************
  // Bus slave state
  // ****************************************
  bcrc_state_type state_ff, nxt_state;
  bcrc_req_type req_ff, nxt_req;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic hreadyout_ff, nxt_hreadyout;
  logic hresp_ff;
  logic addr_phase;
  logic [7:0] read_byte;

  assign addr_phase = hsel && hready && htrans[1];

  // ****************************************
  // CRC datapath
  // ****************************************
  // Choice is read live, so a control write lands before the next byte
  bcrc_byte_step u_step
  (
    .sum_in(running_checksum_ff),
    .data_in(hwdata[7:0]),
    .gen_sel(gen_choice_ff),
    .sum_out(stepped_sum)
  );

  // ****************************************
  // Read mux
  // ****************************************
  always_comb
  begin
    read_byte = 8'h00;
    if (req_ff.addr == `BCRC_OFS_CONTROL)
    begin
      read_byte = {7'h00, gen_choice_ff};
    end
    else if (req_ff.addr == `BCRC_OFS_INPUT)
    begin
      read_byte = byte_input_ff;
    end
    else if (req_ff.addr == `BCRC_OFS_SUM_LOW)
    begin
      read_byte = running_checksum_ff[7:0];
    end
    else if (req_ff.addr == `BCRC_OFS_SUM_HIGH)
    begin
      read_byte = running_checksum_ff[15:8];
    end
  end

  // ****************************************
  // Bus control next state
  // ****************************************
  always_comb
  begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_hrdata = hrdata_ff;
    nxt_hreadyout = hreadyout_ff;
    case (state_ff)
      BCRC_ST_IDLE:
      begin
        nxt_hreadyout = 1'b1;
        if (addr_phase)
        begin
          nxt_req.addr = haddr[11:0];
          nxt_req.write = hwrite;
          if (hwrite)
          begin
            nxt_state = BCRC_ST_WRITE;
          end
          else
          begin
            // Read data is sampled one cycle later so it sees any update
            nxt_state = BCRC_ST_READ;
            nxt_hreadyout = 1'b0;
          end
        end
      end
      BCRC_ST_WRITE:
      begin
        nxt_hreadyout = 1'b1;
        nxt_state = BCRC_ST_IDLE;
        if (addr_phase)
        begin
          nxt_req.addr = haddr[11:0];
          nxt_req.write = hwrite;
          nxt_state = hwrite ? BCRC_ST_WRITE : BCRC_ST_READ;
          nxt_hreadyout = hwrite;
        end
      end
      BCRC_ST_READ:
      begin
        if (!hreadyout_ff)
        begin
          nxt_hrdata = {24'h000000, read_byte};
          nxt_hreadyout = 1'b1;
        end
        else
        begin
          nxt_state = BCRC_ST_IDLE;
          if (addr_phase)
          begin
            nxt_req.addr = haddr[11:0];
            nxt_req.write = hwrite;
            nxt_state = hwrite ? BCRC_ST_WRITE : BCRC_ST_READ;
            nxt_hreadyout = hwrite;
          end
        end
      end
      default:
      begin
        nxt_state = BCRC_ST_IDLE;
        nxt_hreadyout = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Register file next state
  // ****************************************
  always_comb
  begin
    nxt_gen_choice = gen_choice_ff;
    nxt_byte_input = byte_input_ff;
    nxt_running_checksum = running_checksum_ff;
    if (state_ff == BCRC_ST_WRITE)
    begin
      if (req_ff.addr == `BCRC_OFS_CONTROL)
      begin
        nxt_gen_choice = bcrc_gen_type'(hwdata[`BCRC_GEN_CHOICE_BIT]);
      end
      else if (req_ff.addr == `BCRC_OFS_INPUT)
      begin
        nxt_byte_input = hwdata[7:0];
        nxt_running_checksum = stepped_sum;
      end
      else if (req_ff.addr == `BCRC_OFS_SUM_LOW)
      begin
        nxt_running_checksum[7:0] = hwdata[7:0];
      end
      else if (req_ff.addr == `BCRC_OFS_SUM_HIGH)
      begin
        nxt_running_checksum[15:8] = hwdata[7:0];
      end
    end
  end

  // ****************************************
  // Flip-flops
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff <= BCRC_ST_IDLE;
      req_ff <= '0;
      hrdata_ff <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      gen_choice_ff <= BCRC_GEN_CCITT;
      byte_input_ff <= `BCRC_INPUT_RST;
      running_checksum_ff <= `BCRC_SUM_RST;
    end
    else
    begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= nxt_hreadyout;
      // Errors are never signalled, so this flop only ever holds OKAY
      hresp_ff <= 1'b0;
      gen_choice_ff <= nxt_gen_choice;
      byte_input_ff <= nxt_byte_input;
      running_checksum_ff <= nxt_running_checksum;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;

  // ****************************************
  // Checks
  // ****************************************
  logic input_write;
  assign input_write = (state_ff == BCRC_ST_WRITE) && (req_ff.addr == `BCRC_OFS_INPUT);

  update_one_cycle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    input_write |=> running_checksum_ff == $past(stepped_sum))
    else $error("checksum not updated in one cycle");

  ccitt_single_a: assert property (@(posedge hclk) disable iff (!hresetn)
    input_write && running_checksum_ff == 16'h0000 && hwdata[7:0] == 8'h01
      && gen_choice_ff == BCRC_GEN_CCITT |=> running_checksum_ff == 16'h1021)
    else $error("ccitt feedback wrong");

  crc16_single_a: assert property (@(posedge hclk) disable iff (!hresetn)
    input_write && running_checksum_ff == 16'h0000 && hwdata[7:0] == 8'h02
      && gen_choice_ff == BCRC_GEN_CRC16 |=> running_checksum_ff == 16'h800f)
    else $error("crc16 feedback wrong");

  zero_stays_a: assert property (@(posedge hclk) disable iff (!hresetn)
    input_write && running_checksum_ff == 16'h0000 && hwdata[7:0] == 8'h00
      |=> running_checksum_ff == 16'h0000)
    else $error("zero byte changed zero checksum");

  input_echo_a: assert property (@(posedge hclk) disable iff (!hresetn)
    input_write |=> byte_input_ff == $past(hwdata[7:0]))
    else $error("input register lost byte");

  control_bits_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == BCRC_ST_READ && !hreadyout_ff && req_ff.addr == `BCRC_OFS_CONTROL
      |=> hrdata_ff[31:1] == 31'h0)
    else $error("control upper bits not zero");

  sum_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff != BCRC_ST_WRITE |=> $stable(running_checksum_ff))
    else $error("checksum changed without write");

  high_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == BCRC_ST_WRITE && req_ff.addr == `BCRC_OFS_SUM_HIGH
      |=> running_checksum_ff[15:8] == $past(hwdata[7:0])
        && running_checksum_ff[7:0] == $past(running_checksum_ff[7:0]))
    else $error("high byte write wrong");

  read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_phase && !hwrite |=> !hreadyout_ff ##1 hreadyout_ff)
    else $error("read wait state wrong");

  // ****************************************
  // Bus and register checks
  // ****************************************
  // A read sits in its wait cycle while hreadyout_ff is low
  logic read_fill;
  logic mapped_addr;
  assign read_fill = (state_ff == BCRC_ST_READ) && !hreadyout_ff;
  assign mapped_addr = (req_ff.addr == `BCRC_OFS_CONTROL)
    || (req_ff.addr == `BCRC_OFS_INPUT) || (req_ff.addr == `BCRC_OFS_SUM_LOW)
    || (req_ff.addr == `BCRC_OFS_SUM_HIGH);

  write_no_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_phase && hwrite |=> hreadyout_ff)
    else $error("write inserted a wait state");

  low_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == BCRC_ST_WRITE && req_ff.addr == `BCRC_OFS_SUM_LOW
      |=> running_checksum_ff[7:0] == $past(hwdata[7:0])
        && running_checksum_ff[15:8] == $past(running_checksum_ff[15:8]))
    else $error("low byte write wrong");

  control_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == BCRC_ST_WRITE && req_ff.addr == `BCRC_OFS_CONTROL
      |=> gen_choice_ff == $past(hwdata[`BCRC_GEN_CHOICE_BIT]))
    else $error("generator choice not written");

  choice_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(state_ff == BCRC_ST_WRITE && req_ff.addr == `BCRC_OFS_CONTROL)
      |=> $stable(gen_choice_ff))
    else $error("generator choice changed without write");

  input_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !input_write |=> $stable(byte_input_ff))
    else $error("input register changed without write");

  crc16_from_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    input_write && running_checksum_ff == 16'h0000 && hwdata[7:0] == 8'h01
      && gen_choice_ff == BCRC_GEN_CRC16 |=> running_checksum_ff == 16'h8005)
    else $error("generator choice not applied to update");

  high_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    read_fill && req_ff.addr == `BCRC_OFS_SUM_HIGH
      |=> hrdata_ff == {24'h000000, $past(running_checksum_ff[15:8])})
    else $error("high byte read wrong");

  low_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    read_fill && req_ff.addr == `BCRC_OFS_SUM_LOW
      |=> hrdata_ff == {24'h000000, $past(running_checksum_ff[7:0])})
    else $error("low byte read wrong");

  input_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    read_fill && req_ff.addr == `BCRC_OFS_INPUT
      |=> hrdata_ff == {24'h000000, $past(byte_input_ff)})
    else $error("input read back wrong");

  unmapped_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    read_fill && !mapped_addr |=> hrdata_ff == 32'h00000000)
    else $error("unmapped read not zero");

  data_stands_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !read_fill |=> $stable(hrdata_ff))
    else $error("read data changed outside a read");

  // ****************************************
  // Coverage
  // ****************************************
  input_write_c: cover property (@(posedge hclk) disable iff (!hresetn) input_write);
  chain_c: cover property (@(posedge hclk) disable iff (!hresetn) input_write ##1 input_write);
  crc16_use_c: cover property (@(posedge hclk) disable iff (!hresetn)
    input_write && gen_choice_ff == BCRC_GEN_CRC16);
  sum_read_c: cover property (@(posedge hclk) disable iff (!hresetn)
    state_ff == BCRC_ST_READ && req_ff.addr == `BCRC_OFS_SUM_HIGH);
  control_write_c: cover property (@(posedge hclk) disable iff (!hresetn)
    state_ff == BCRC_ST_WRITE && req_ff.addr == `BCRC_OFS_CONTROL);

endmodule

/* File: verif/test_byte_wise_crc16_unit.sv */
// Purpose: Self-checking bench for the byte CRC unit over AHB-Lite
// Assumes: One slave, hready tied to hreadyout, word transfers only
// Notes: Reads queue their expected data; a monitor compares on completion
`include "bcrc_map.svh"

module test_byte_wise_crc16_unit;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic rd_ph = 1'b0;
  logic [31:0] exp_q[$];
  int failures = 0;
  int compares = 0;
  logic [7:0] doc_b[4] = '{8'h78, 8'h56, 8'h34, 8'h12};
  logic [15:0] doc_v[2][4] = '{'{16'hff9f, 16'hbbc3, 16'ha367, 16'hd0fa},
                               '{16'h0110, 16'h91f1, 16'hf2de, 16'h5c43}};
  logic [15:0] one_v[2][8] = '{'{16'h0000, 16'h1021, 16'h2042, 16'h3063, 16'h4084, 16'h50a5,
                                 16'h60c6, 16'h70e7},
                               '{16'h0000, 16'h8005, 16'h800f, 16'h000a, 16'h801b, 16'h001e,
                                 16'h0014, 16'h8011}};

  always #20 hclk = ~hclk;

  bcrc_top i_dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp)
  );

  // ****************************************
  // Reporting
  // ****************************************
  task automatic end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic note(input string msg);
    failures++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
      note($sformatf("read %h, expected %h", got, exp));
  endtask

  // ****************************************
  // Monitor: pops the oldest expected value at each read completion
  // ****************************************
  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout === 1'b1)
    begin
      if (exp_q.size() == 0)
        note("read with nothing expected");
      else
        chk(exp_q.pop_front(), hrdata);
      chk(32'h0, {31'h0, hresp});
    end
    if (hreadyout === 1'b1)
      rd_ph = hsel && htrans[1] && !hwrite;
  end

  // ****************************************
  // Bus master
  // ****************************************
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        note("hreadyout stuck low");
        end_sim;
      end
      @(posedge hclk);
    end
  endtask

  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    // Junk in the upper bits must not reach any register
    hwdata <= {24'($urandom()), d};
    wait_rdy;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    xfer(a, 1'b0, 8'h00);
  endtask

  task automatic rd_sum(input logic [15:0] e);
    rd(`BCRC_OFS_SUM_HIGH, e[15:8]);
    rd(`BCRC_OFS_SUM_LOW, e[7:0]);
  endtask

  function automatic logic [15:0] crc_ref(input logic [15:0] s, input logic [7:0] b,
                                          input logic g);
    logic [15:0] t;
    t = s ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
      t = t[15] ? {t[14:0], 1'b0} ^ (g ? `BCRC_FB_CRC16 : `BCRC_FB_CCITT) : {t[14:0], 1'b0};
    return t;
  endfunction

  task automatic check_reset;
    rd(`BCRC_OFS_CONTROL, 8'h00);
    rd(`BCRC_OFS_INPUT, 8'h00);
    rd_sum(16'h0000);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [15:0] sum;
    logic [7:0] b;
    logic g;
    void'($urandom(59));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_reset;
    rd(12'h010, 8'h00);
    wr(`BCRC_OFS_CONTROL, 8'hff);
    rd(`BCRC_OFS_CONTROL, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      wr(`BCRC_OFS_CONTROL, 8'(k));
      // Single bytes from a cleared pair, as in the one-byte table
      for (int j = 0; j < 8; j++)
      begin
        wr(`BCRC_OFS_SUM_LOW, 8'h00);
        wr(`BCRC_OFS_SUM_HIGH, 8'h00);
        wr(`BCRC_OFS_INPUT, 8'(j));
        rd_sum(one_v[k][j]);
      end
      wr(`BCRC_OFS_SUM_LOW, 8'h00);
      wr(`BCRC_OFS_SUM_HIGH, 8'h00);
      for (int j = 0; j < 4; j++)
      begin
        wr(`BCRC_OFS_INPUT, doc_b[j]);
        rd_sum(doc_v[k][j]);
      end
      rd(`BCRC_OFS_INPUT, 8'h12);
    end
    // Random seeds, generator flips and input writes, each after its own control write
    sum = 16'h0;
    for (int i = 0; i < 24; i++)
    begin
      if (i % 4 == 0)
      begin
        sum = 16'($urandom());
        wr(`BCRC_OFS_SUM_HIGH, sum[15:8]);
        wr(`BCRC_OFS_SUM_LOW, sum[7:0]);
      end
      g = 1'($urandom());
      b = 8'($urandom());
      wr(`BCRC_OFS_CONTROL, {7'h0, g});
      wr(`BCRC_OFS_INPUT, b);
      sum = crc_ref(sum, b, g);
      if (i % 3 != 0)
        rd_sum(sum);
    end
    rd(`BCRC_OFS_INPUT, b);
    // Second reset in mid-run must clear everything again
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_reset;
    repeat (2) @(posedge hclk);
    if (exp_q.size() != 0)
      note("reads left unanswered");
    end_sim;
  end
endmodule
